/* File: hw/rei_top.sv */
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
module rei_top (
    input  wire logic        pclk,                  // 40 MHz clock
    input  wire logic        presetn,               // Async reset, low
    input  wire logic        psel,                  // APB select
    input  wire logic        penable,               // APB enable
    input  wire logic        pwrite,                // APB direction
    input  wire logic [7:0]  paddr,                 // APB byte address
    input  wire logic [31:0] pwdata,                // APB write data
    output logic      [31:0] prdata,                // APB read data
    output logic             pready,                // APB ready
    output logic             pslverr,               // APB error
    input  wire logic        rst_pin_in,            // Reset line level
    output logic             rst_pin_out,           // Reset line drive value
    output logic             rst_pin_oe,            // Reset line drive enable
    input  wire logic        in_system_prog_select, // Programming select pin
    input  wire logic        ext_event_line_a,      // Event line A
    input  wire logic        ext_event_line_b,      // Event line B
    input  wire logic        count_input_a,         // Count input A
    input  wire logic        wdt_timeout,           // Watchdog time-out pulse
    output logic             sys_reset,             // Qualified device reset
    output logic             port_reset_force,      // Ports to reset state
    output logic             isp_mode,              // Programming mode latched
    output logic             idle_mode,             // Idle mode
    output logic             powerdown_mode,        // Power-down mode
    output logic             timer_run_a,           // Timer zero run
    output logic             timer_run_b,           // Timer one run
    output logic             irq                    // Interrupt, high
);
    rei_pkg::rei_state_t st;
    rei_pkg::rei_state_t next_st;

    logic lvl_a;
    logic fall_a;
    logic lvl_b;
    logic fall_b;
    logic lvl_cnt;
    logic fall_cnt;
    logic lvl_rst;
    logic lvl_isp;
    logic wdt_active;
    logic wdt_done;
    logic force_q;
    logic rst_any_n;
    logic wr_cycle;
    logic rd_cycle;
    logic set_a;
    logic set_b;
    logic count_tick;

    ////////////////////////////////////////////////////////////////////////////
    rei_sync_edge u_sync_a (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (ext_event_line_a),
        .level   (lvl_a),
        .fall    (fall_a)
    );

    rei_sync_edge u_sync_b (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (ext_event_line_b),
        .level   (lvl_b),
        .fall    (fall_b)
    );

    rei_sync_edge u_sync_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (count_input_a),
        .level   (lvl_cnt),
        .fall    (fall_cnt)
    );

    rei_sync_edge u_sync_rst (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (rst_pin_in),
        .level   (lvl_rst),
        .fall    ()
    );

    rei_sync_edge u_sync_isp (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (in_system_prog_select),
        .level   (lvl_isp),
        .fall    ()
    );

    // The watchdog pulse is longer than the filter, so it also resets us
    rei_pulse_gen #(
        .LEN (rei_pkg::WDT_PULSE_CYCLES)
    ) u_wdt_pulse (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (wdt_timeout),
        .active  (wdt_active),
        .done    (wdt_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Port force must work with the oscillator stopped
    assign rst_any_n = rst_pin_in & presetn;

    always_ff @(posedge pclk or negedge rst_any_n) begin
        if (!rst_any_n) begin
            force_q <= 1'b1;
        end else begin
            force_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One wait state: pready rises in the second access cycle
    assign wr_cycle   = psel & penable & st.pready & pwrite;
    assign rd_cycle   = psel & penable & ~st.pready;
    assign set_a      = st.ctrl.edge_select_a ? fall_a : ~lvl_a;
    assign set_b      = st.ctrl.edge_select_b ? fall_b : ~lvl_b;
    assign count_tick = fall_cnt & st.ctrl.count_mode_a & st.run_a;

    always_comb begin
        logic [rei_pkg::ST_W-1:0] clr;
        logic [rei_pkg::ST_W-1:0] set;
        logic                     hit;
        logic [31:0]              rdat;
        clr  = '0;
        set  = '0;
        hit  = 1'b1;
        rdat = 32'h0000_0000;

        next_st         = st;
        next_st.pready  = rd_cycle;
        next_st.pslverr = 1'b0;
        next_st.prdata  = 32'h0000_0000;

        case (paddr)
            rei_pkg::OFS_CTRL:   rdat = 32'(st.ctrl);
            rei_pkg::OFS_STATUS: rdat = 32'(st.status);
            rei_pkg::OFS_CLEAR:  rdat = 32'h0000_0000;
            rei_pkg::OFS_ENABLE: rdat = 32'(st.enable);
            rei_pkg::OFS_COUNT:  rdat = 32'(st.count);
            rei_pkg::OFS_MODE:   rdat = {29'h0, st.isp_mode, st.pdown, st.idle};
            default:             hit  = 1'b0;
        endcase

        if (rd_cycle) begin
            next_st.pslverr = ~hit;
            next_st.prdata  = pwrite ? 32'h0000_0000 : rdat;
        end

        // Hardware count before software write, so a write wins
        if (count_tick) begin
            next_st.count = st.count + 16'h0001;
        end

        if (wr_cycle) begin
            case (paddr)
                rei_pkg::OFS_CTRL:   next_st.ctrl   = rei_pkg::rei_ctrl_t'(pwdata[rei_pkg::CTRL_W-1:0]);
                rei_pkg::OFS_CLEAR:  clr            = pwdata[rei_pkg::ST_W-1:0];
                rei_pkg::OFS_ENABLE: next_st.enable = pwdata[rei_pkg::ST_W-1:0];
                rei_pkg::OFS_COUNT:  next_st.count  = pwdata[rei_pkg::COUNT_W-1:0];
                rei_pkg::OFS_MODE: begin
                    next_st.idle  = pwdata[rei_pkg::MODE_IDLE];
                    next_st.pdown = pwdata[rei_pkg::MODE_PDOWN];
                end
                default: ;
            endcase
        end

        set[rei_pkg::ST_EVENT_A]   = set_a;
        set[rei_pkg::ST_EVENT_B]   = set_b;
        set[rei_pkg::ST_WDT_DONE]  = wdt_done;
        set[rei_pkg::ST_COUNT_OVF] = count_tick & (st.count == 16'hFFFF);
        // Set beats clear in the same cycle
        next_st.status = (st.status & ~clr) | set;

        // Filter: count low samples, saturate at the threshold
        if (lvl_rst) begin
            next_st.rst_cnt = 7'h00;
        end else if (st.rst_cnt != 7'(rei_pkg::RST_QUAL_CYCLES)) begin
            next_st.rst_cnt = st.rst_cnt + 7'h01;
        end
        next_st.sys_reset = ~lvl_rst && (st.rst_cnt >= 7'(rei_pkg::RST_QUAL_CYCLES - 1));

        if (st.sys_reset) begin
            next_st.idle     = 1'b0;
            next_st.pdown    = 1'b0;
            next_st.isp_capt = lvl_isp;
            if (!next_st.sys_reset) begin
                next_st.isp_mode = st.isp_capt;
            end
        end

        next_st.run_a = st.ctrl.run_a & (~st.ctrl.run_gate_sel_a | lvl_a);
        next_st.run_b = st.ctrl.run_b & (~st.ctrl.run_gate_sel_b | lvl_b);
        next_st.irq   = |(next_st.status & next_st.enable);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign prdata           = st.prdata;
    assign pready           = st.pready;
    assign pslverr          = st.pslverr;
    assign rst_pin_out      = 1'b0;
    assign rst_pin_oe       = wdt_active;
    assign sys_reset        = st.sys_reset;
    assign port_reset_force = force_q;
    assign isp_mode         = st.isp_mode;
    assign idle_mode        = st.idle;
    assign powerdown_mode   = st.pdown;
    assign timer_run_a      = st.run_a;
    assign timer_run_b      = st.run_b;
    assign irq              = st.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Checking helpers
    logic [7:0] oe_len;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_len <= 8'h00;
        end else begin
            oe_len <= rst_pin_oe ? oe_len + 8'h01 : 8'h00;
        end
    end

    reset_qual_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sys_reset) |-> $past(st.rst_cnt) >= 7'd63 && !$past(lvl_rst))
        else $error("reset raised before 64 low samples");

    port_force_a: assert property (@(posedge pclk) disable iff (!presetn)
        !rst_pin_in |-> port_reset_force) else $error("ports not forced while reset line low");

    reset_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
        sys_reset |=> !idle_mode && !powerdown_mode) else $error("low power mode kept through reset");

    wdt_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(rst_pin_oe) |-> $past(oe_len) == 8'd95) else $error("watchdog pulse not 96 cycles");

    isp_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(sys_reset) |-> isp_mode == $past(st.isp_capt)) else $error("programming select not latched");

    gate_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.ctrl.run_gate_sel_a && !lvl_a) |=> !timer_run_a) else $error("timer zero ran with gate low");

    event_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.ctrl.edge_select_a ? fall_a : !lvl_a) |=> st.status[rei_pkg::ST_EVENT_A])
        else $error("event flag A not set");

    event_flag_b_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!st.ctrl.edge_select_b && !lvl_b) |=> st.status[rei_pkg::ST_EVENT_B])
        else $error("event flag B not set by low level");

    gate_run_b_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.ctrl.run_b && (!st.ctrl.run_gate_sel_b || lvl_b)) |=> timer_run_b)
        else $error("timer one not running");

    count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        (count_tick && !(wr_cycle && paddr == rei_pkg::OFS_COUNT)) |=> st.count == $past(st.count) + 16'h0001)
        else $error("count did not advance by one");

    // Further guards on the flags, reset, programming mode, the line drive, timer one, the counter, the interrupt and ready
    edge_flag_b_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.ctrl.edge_select_b && fall_b) |=> st.status[rei_pkg::ST_EVENT_B])
        else $error("event flag B not set by falling edge");

    flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.status[rei_pkg::ST_EVENT_A] && !(wr_cycle && paddr == rei_pkg::OFS_CLEAR && pwdata[rei_pkg::ST_EVENT_A]))
        |=> st.status[rei_pkg::ST_EVENT_A]) else $error("event flag A lost without a clear");

    reset_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        lvl_rst |=> !sys_reset)
        else $error("qualified reset held with reset line high");

    isp_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(isp_mode) |-> $fell(sys_reset))
        else $error("programming mode changed outside reset end");

    wdt_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wdt_timeout && !rst_pin_oe) |=> rst_pin_oe)
        else $error("watchdog time-out did not start the line pulse");

    line_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        rst_pin_oe |-> !rst_pin_out)
        else $error("reset line driven high");

    run_stop_b_a: assert property (@(posedge pclk) disable iff (!presetn)
        (st.ctrl.run_gate_sel_b && !lvl_b) |=> !timer_run_b)
        else $error("timer one ran with gate low");

    count_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (fall_cnt && !st.ctrl.count_mode_a && !(wr_cycle && paddr == rei_pkg::OFS_COUNT))
        |=> st.count == $past(st.count))
        else $error("count moved outside counter mode");

    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(st.status & st.enable))
        else $error("interrupt does not follow enabled status");

    pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held for more than one cycle");
endmodule

/* File: inc/rei_pkg.sv */
package rei_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_CLEAR  = 8'h08;
    localparam logic [7:0] OFS_ENABLE = 8'h0C;
    localparam logic [7:0] OFS_COUNT  = 8'h10;
    localparam logic [7:0] OFS_MODE   = 8'h14;

    localparam int ST_EVENT_A   = 0;
    localparam int ST_EVENT_B   = 1;
    localparam int ST_WDT_DONE  = 2;
    localparam int ST_COUNT_OVF = 3;
    localparam int ST_W         = 4;

    localparam int MODE_IDLE  = 0;
    localparam int MODE_PDOWN = 1;
    localparam int MODE_ISP   = 2;

    localparam int CTRL_W  = 7;
    localparam int COUNT_W = 16;

    localparam int          RST_QUAL_CYCLES  = 64;
    localparam int          WDT_PULSE_CYCLES = 96;
    localparam int          RST_CNT_W        = 7;
    localparam logic [15:0] COUNT_RESET      = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic count_mode_a;
        logic run_b;
        logic run_a;
        logic run_gate_sel_b;
        logic run_gate_sel_a;
        logic edge_select_b;
        logic edge_select_a;
    } rei_ctrl_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } rei_sync_t;

    typedef struct packed {
        logic [6:0] cnt;
        logic       active;
        logic       done;
    } rei_pulse_t;

    typedef struct packed {
        rei_ctrl_t          ctrl;
        logic [ST_W-1:0]    enable;
        logic [ST_W-1:0]    status;
        logic [COUNT_W-1:0] count;
        logic               idle;
        logic               pdown;
        logic               isp_capt;
        logic               isp_mode;
        logic [6:0]         rst_cnt;
        logic               sys_reset;
        logic               run_a;
        logic               run_b;
        logic               irq;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
    } rei_state_t;

endpackage

/* File: hw/rei_sync_edge.sv */
`timescale 1ns/100ps
module rei_sync_edge (
    input  wire logic pclk,    // Clock
    input  wire logic presetn, // Async reset, low
    input  wire logic din,     // Raw pin level
    output logic      level,   // Synchronised level
    output logic      fall     // One-cycle falling edge pulse
);
    rei_pkg::rei_sync_t st;
    rei_pkg::rei_sync_t next_st;

    // Idle-high lines reset high so no false edge at release
    always_comb begin
        next_st    = st;
        next_st.s1 = din;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= 3'h7;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.s2;
    assign fall  = st.s3 & ~st.s2;

    edge_shape_a: assert property (@(posedge pclk) disable iff (!presetn)
        fall |-> $past(level) && !level) else $error("edge pulse without high then low sample");
endmodule

/* File: hw/rei_pulse_gen.sv */
`timescale 1ns/100ps
module rei_pulse_gen #(
    parameter int LEN = rei_pkg::WDT_PULSE_CYCLES
) (
    input  wire logic pclk,    // Clock
    input  wire logic presetn, // Async reset, low
    input  wire logic start,   // Start pulse
    output logic      active,  // High for LEN cycles
    output logic      done     // One cycle after the last active cycle
);
    rei_pkg::rei_pulse_t st;
    rei_pkg::rei_pulse_t next_st;

    // A start during a running pulse is ignored, no retrigger
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        if (st.active) begin
            if (st.cnt == 7'(LEN - 1)) begin
                next_st.active = 1'b0;
                next_st.done   = 1'b1;
                next_st.cnt    = 7'h00;
            end else begin
                next_st.cnt = st.cnt + 7'h01;
            end
        end else if (start) begin
            next_st.active = 1'b1;
            next_st.cnt    = 7'h00;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign active = st.active;
    assign done   = st.done;
endmodule

/* File: dv/rei_far_side.sv */
`timescale 1ns/100ps
module rei_far_side (
    input  wire logic pclk,        // Clock
    input  wire logic rst_pin_out, // Device drive value
    input  wire logic rst_pin_oe,  // Device drive enable
    output logic      rst_line,    // Resolved reset line
    output logic      isp_sel,     // Programming select
    output logic      line_a,      // Event line A
    output logic      line_b,      // Event line B
    output logic      cnt_a        // Count pulses
);
    logic ext_low;

    initial begin
        ext_low = 1'b0;
        isp_sel = 1'b0;
        line_a  = 1'b1;
        line_b  = 1'b1;
        cnt_a   = 1'b1;
    end

    // Pull-up: line is high unless some party pulls it low
    assign rst_line = ~((rst_pin_oe & ~rst_pin_out) | ext_low);

    ////////////////////////////////////////////////////////////////////////////
    // Select is held past release so it is still seen at the end of reset
    task automatic hold_rst(input int n, input logic sel);
        @(posedge pclk);
        ext_low <= 1'b1;
        isp_sel <= sel;
        repeat (n) @(posedge pclk);
        ext_low <= 1'b0;
        repeat (6) @(posedge pclk);
        isp_sel <= 1'b0;
    endtask

    task automatic set_line(input int w, input logic v);
        @(posedge pclk);
        if (w == 0) line_a <= v;
        else if (w == 1) line_b <= v;
        else cnt_a <= v;
    endtask

    // Two cycles each way, so the synchroniser sees both levels
    task automatic pulse(input int w);
        set_line(w, 1'b0);
        @(posedge pclk);
        set_line(w, 1'b1);
        @(posedge pclk);
    endtask
endmodule

/* File: dv/test_reset_and_event_inputs.sv */
`timescale 1ns/100ps
module test_reset_and_event_inputs;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        rst_line, rst_pin_out, rst_pin_oe, isp_sel, line_a, line_b, cnt_a, wdt_timeout;
    logic        sys_reset, port_reset_force, isp_mode, idle_mode, powerdown_mode;
    logic        timer_run_a, timer_run_b, irq, saw_sys;
    int          failures, compares, cycles, n;

    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;

    rei_top u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rst_pin_in(rst_line), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
        .in_system_prog_select(isp_sel), .ext_event_line_a(line_a), .ext_event_line_b(line_b),
        .count_input_a(cnt_a), .wdt_timeout(wdt_timeout), .sys_reset(sys_reset),
        .port_reset_force(port_reset_force), .isp_mode(isp_mode), .idle_mode(idle_mode),
        .powerdown_mode(powerdown_mode), .timer_run_a(timer_run_a), .timer_run_b(timer_run_b), .irq(irq)
    );

    rei_far_side u_far (
        .pclk(pclk), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .rst_line(rst_line),
        .isp_sel(isp_sel), .line_a(line_a), .line_b(line_b), .cnt_a(cnt_a)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // No fixed latency assumed: wait for pready, bounded by the run timeout
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(q, exp);
    endtask

    task automatic wt(input int k);
        repeat (k) @(posedge pclk);
    endtask

    // Flag is set in both modes; only level mode sets it again after a clear
    task automatic ev_case(input int w, input logic edge_mode);
        wr(rei_pkg::OFS_CTRL, edge_mode ? (32'h1 << w) : 32'h0);
        u_far.set_line(w, 1'b0);
        wt(6);
        chk_bit(irq, 1'b1);
        rd_chk(rei_pkg::OFS_STATUS, 32'h1 << w);
        wr(rei_pkg::OFS_CLEAR, 32'h1 << w);
        rd_chk(rei_pkg::OFS_STATUS, edge_mode ? 32'h0 : (32'h1 << w));
        u_far.set_line(w, 1'b1);
        wt(4);
        wr(rei_pkg::OFS_CLEAR, 32'h3);
        rd_chk(rei_pkg::OFS_STATUS, 32'h0);
        chk_bit(irq, 1'b0);
    endtask

    always @(posedge pclk) begin
        if (sys_reset === 1'b1) saw_sys <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            failures++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h00000000; wdt_timeout = 1'b0; saw_sys = 1'b0;
        failures = 0; compares = 0; cycles = 0; n = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) rd_chk(8'(i * 4), 32'h00000000);
        wr(rei_pkg::OFS_STATUS, 32'h0000000F);
        rd_chk(rei_pkg::OFS_STATUS, 32'h00000000);
        apb(1'b0, 8'h18, 32'h00000000);
        chk_bit(err, 1'b1);
        chk(q, 32'h00000000);
        // Event flags, both lines in both modes
        wr(rei_pkg::OFS_ENABLE, 32'h3);
        for (int e = 0; e < 2; e++) begin
            ev_case(0, e[0]);
            ev_case(1, e[0]);
        end
        // Run gates
        wr(rei_pkg::OFS_CTRL, 32'h3C);
        wt(4);
        chk_bit(timer_run_a, 1'b1);
        chk_bit(timer_run_b, 1'b1);
        u_far.set_line(0, 1'b0);
        u_far.set_line(1, 1'b0);
        wt(4);
        chk_bit(timer_run_a, 1'b0);
        chk_bit(timer_run_b, 1'b0);
        wr(rei_pkg::OFS_CTRL, 32'h30);
        wt(4);
        chk_bit(timer_run_a, 1'b1);
        chk_bit(timer_run_b, 1'b1);
        u_far.set_line(0, 1'b1);
        u_far.set_line(1, 1'b1);
        wt(4);
        wr(rei_pkg::OFS_CLEAR, 32'hF);
        // Counter mode, wrap and overflow flag
        wr(rei_pkg::OFS_CTRL, 32'h50);
        wt(3);
        repeat (5) u_far.pulse(2);
        wt(3);
        rd_chk(rei_pkg::OFS_COUNT, 32'h5);
        wr(rei_pkg::OFS_COUNT, 32'hFFFF);
        u_far.pulse(2);
        wt(3);
        rd_chk(rei_pkg::OFS_COUNT, 32'h0);
        rd_chk(rei_pkg::OFS_STATUS, 32'h8);
        wr(rei_pkg::OFS_CTRL, 32'h0);
        u_far.pulse(2);
        wt(3);
        rd_chk(rei_pkg::OFS_COUNT, 32'h0);
        wr(rei_pkg::OFS_CLEAR, 32'hF);
        // Reset filter, wake and programming select
        wr(rei_pkg::OFS_MODE, 32'h3);
        wt(1);
        chk_bit(powerdown_mode, 1'b1);
        saw_sys = 1'b0;
        fork
            u_far.hold_rst(63, 1'b0);
            begin
                @(posedge pclk);
                @(negedge pclk);
                chk_bit(port_reset_force, 1'b1);
            end
        join
        chk_bit(saw_sys, 1'b0);
        chk_bit(idle_mode, 1'b1);
        u_far.hold_rst(70, 1'b1);
        wt(2);
        chk_bit(saw_sys, 1'b1);
        chk_bit(port_reset_force, 1'b0);
        chk_bit(isp_mode, 1'b1);
        chk_bit(idle_mode, 1'b0);
        chk_bit(powerdown_mode, 1'b0);
        rd_chk(rei_pkg::OFS_MODE, 32'h4);
        // Watchdog pulse on the line, masked then enabled interrupt
        wr(rei_pkg::OFS_ENABLE, 32'h0);
        wr(rei_pkg::OFS_CLEAR, 32'hF);
        @(posedge pclk);
        wdt_timeout <= 1'b1;
        @(posedge pclk);
        wdt_timeout <= 1'b0;
        repeat (150) begin
            @(posedge pclk);
            if (rst_pin_oe === 1'b1 && rst_pin_out === 1'b0) n++;
        end
        chk(32'(n), 32'd96);
        chk_bit(irq, 1'b0);
        rd_chk(rei_pkg::OFS_STATUS, 32'h4);
        wr(rei_pkg::OFS_ENABLE, 32'h4);
        wt(1);
        chk_bit(irq, 1'b1);
        wr(rei_pkg::OFS_CLEAR, 32'h4);
        wt(1);
        chk_bit(irq, 1'b0);
        conclude();
    end
endmodule
